// ===== rtl/spc_buf2.v
// two-entry valid/ready buffer in the audio word path
`timescale 1ns/1ps
module spc_buf2 #(
	parameter W     = 32,
	parameter DEPTH = 2
) (
	input  wire         clock_i,
	input  wire         rst_n_i,
	input  wire         clear_i,
	input  wire [W-1:0] in_data_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	output wire [W-1:0] out_data_o,
	output wire         out_valid_o,
	input  wire         out_ready_i
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg         wr;
	reg         rd;
	reg [1:0]   cnt;
	wire        push;
	wire        pop;
	integer     k;

	assign in_ready_o  = (cnt != 2'h2);
	assign out_valid_o = (cnt != 2'h0);
	assign out_data_o  = mem[rd];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr  <= 1'b0;
			rd  <= 1'b0;
			cnt <= 2'h0;
			for (k = 0; k < DEPTH; k = k + 1) begin
				mem[k] <= {W{1'b0}};
			end
		end else if (clear_i) begin
			wr  <= 1'b0;
			rd  <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (push) begin
				mem[wr] <= in_data_i;
				wr      <= ~wr;
			end
			if (pop) begin
				rd <= ~rd;
			end
			if (push && !pop) begin
				cnt <= cnt + 2'h1;
			end else if (pop && !push) begin
				cnt <= cnt - 2'h1;
			end
		end
	end
endmodule // spc_buf2

// ===== rtl/spc_consts.vh
// constants for the pin mode and power-down control block
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH
`define SPC_CLK_MHZ       125
`define SPC_UNLOCK_US     100
`define SPC_MUTE_STEP_US  4
`define SPC_FRAME_CYC     3072
`define SPC_FRAME_BITS    64
`define SPC_SLOT_BITS     6'h20
`define SPC_SLOT_LAST     6'h1f
`define SPC_DSD_LAST      4'hf
`define SPC_TDM_LAST      3'h7
`define SPC_STEREO_LAST   3'h1
`define SPC_WORD_W        32
`define SPC_GAIN_W        8
`define SPC_FMT_MSB       2'h0
`define SPC_FMT_I2S       2'h1
`define SPC_FMT_LSB       2'h2
`define SPC_WL_0          6'h20
`define SPC_WL_1          6'h18
`define SPC_WL_2          6'h14
`define SPC_WL_3          6'h10
`define SPC_MCK_R0        64
`define SPC_MCK_R1        128
`define SPC_MCK_R2        192
`define SPC_MCK_R3        256
`define SPC_MCK_R4        384
`define SPC_MCK_R5        512
`define SPC_MCK_R6        768
`define SPC_MCK_R7        256
`define SPC_CM_XT_OFF_A   4'h6
`define SPC_CM_XT_OFF_B   4'h7
`define SPC_REF_XTAL      2'h0
`define SPC_REF_EXT       2'h1
`define SPC_REF_CHAIN     2'h2
`define SPC_IX_OBCK       5
`define SPC_IX_OLR        6
`define SPC_IX_IBCK       9
`define SPC_IX_ILR        10
`define SPC_IX_DCLK       11
`endif

// ===== rtl/spc_pin_ctrl.v
// pin mode selection, power-down control and audio port framing
`timescale 1ns/1ps
`include "spc_consts.vh"
module spc_pin_ctrl #(
	parameter UNLOCK_CYC    = `SPC_UNLOCK_US * `SPC_CLK_MHZ,
	parameter MUTE_STEP_CYC = `SPC_MUTE_STEP_US * `SPC_CLK_MHZ,
	parameter FRAME_CYC     = `SPC_FRAME_CYC,
	parameter GAIN_W        = `SPC_GAIN_W
) (
	input  wire              clock_i,
	input  wire              rstn_i,
	input  wire              power_down_n_i,
	input  wire              parallel_serial_sel_i,
	input  wire              bus_type_sel_i,
	input  wire [1:0]        chip_addr_straps_i,
	input  wire              input_format_sel_2_i,
	input  wire [1:0]        output_format_sel_i,
	input  wire [1:0]        output_word_length_sel_i,
	input  wire [3:0]        output_clock_mode_sel_i,
	input  wire              tdm_sel_i,
	input  wire              soft_mute_pin_i,
	input  wire              mute_semi_auto_sel_i,
	input  wire [1:0]        mute_time_sel_i,
	input  wire              dither_enable_i,
	input  wire              onebit_in_left_i,
	input  wire              onebit_in_right_i,
	input  wire              onebit_in_clock_i,
	input  wire              in_frame_clock_i,
	input  wire              in_bit_clock_i,
	input  wire              serial_audio_in_i,
	input  wire              onebit_mode_sel_i,
	input  wire              out_frame_clock_i,
	input  wire              out_bit_clock_i,
	input  wire              ref_clock_source_sel_i,
	input  wire              crystal_in_i,
	input  wire              control_data_in_i,
	input  wire              control_clock_i,
	input  wire              control_chip_select_n_i,
	input  wire              reg_soft_mute_i,
	input  wire              reg_slow_filter_i,
	input  wire              reg_short_delay_i,
	input  wire              ctl_reply_i,
	output reg               out_frame_clock_o,
	output reg               out_frame_clock_oe_o,
	output reg               out_bit_clock_o,
	output reg               out_bit_clock_oe_o,
	output reg               serial_audio_out_o,
	output reg               master_clock_out_o,
	output reg               crystal_drive_out_o,
	output reg               unlock_status_out_o,
	output reg               control_data_out_o,
	output reg               control_data_out_oe_o,
	output reg               sda_o,
	output reg               sda_oe_o,
	output reg               ctl_serial_mode_o,
	output reg               ctl_i2c_mode_o,
	output reg [1:0]         ctl_chip_addr_o,
	output reg               ctl_data_o,
	output reg               ctl_clock_o,
	output reg               ctl_select_n_o,
	output reg [2:0]         input_format_o,
	output reg               filter_slow_o,
	output reg               filter_short_delay_o,
	output reg               dither_on_o,
	output reg [1:0]         deemphasis_o,
	output reg [1:0]         ref_source_o,
	output reg [GAIN_W-1:0]  mute_gain_o,
	output reg               overflow_o
);
	localparam NA = 34;
	localparam WW = `SPC_WORD_W;
	localparam [11:0] BHALF = FRAME_CYC / (2 * `SPC_FRAME_BITS);
	localparam [23:0] UNL = UNLOCK_CYC;
	localparam [15:0] MST = MUTE_STEP_CYC;
	localparam [GAIN_W-1:0] GMAX = {GAIN_W{1'b1}};

	reg  [1:0]    rsync;
	wire          rst_n;
	reg  [NA-1:0] s1;
	reg  [NA-1:0] s2;
	reg  [NA-1:0] s3;
	reg  [NA-1:0] st;
	reg  [NA-1:0] stp;
	wire [NA-1:0] ain;
	wire          pdn_s, psn_s, i2c_s, idif2_s, tdm_s, soft_mute_pin_s, semi_s, dith_s;
	wire          dl_s, dr_s, dclk_s, ilr_s, ibck_s, serial_audio_in_s, dsd_s, olr_s, obck_s;
	wire          cksel_s, xti_s, control_data_in_s, control_clock_s, csn_s;
	wire [1:0]    cad_s, odif_s, obit_s, smt_s;
	wire [3:0]    cm_s;
	wire          pd;

	assign ain = {power_down_n_i, parallel_serial_sel_i, bus_type_sel_i, chip_addr_straps_i,
		input_format_sel_2_i, output_format_sel_i, output_word_length_sel_i,
		output_clock_mode_sel_i, tdm_sel_i, soft_mute_pin_i, mute_semi_auto_sel_i,
		mute_time_sel_i, dither_enable_i, onebit_in_left_i, onebit_in_right_i,
		onebit_in_clock_i, in_frame_clock_i, in_bit_clock_i, serial_audio_in_i,
		onebit_mode_sel_i, out_frame_clock_i, out_bit_clock_i, ref_clock_source_sel_i,
		crystal_in_i, control_data_in_i, control_clock_i, control_chip_select_n_i};
	assign {pdn_s, psn_s, i2c_s, cad_s, idif2_s, odif_s, obit_s, cm_s, tdm_s, soft_mute_pin_s,
		semi_s, smt_s, dith_s, dl_s, dr_s, dclk_s, ilr_s, ibck_s, serial_audio_in_s, dsd_s, olr_s,
		obck_s, cksel_s, xti_s, control_data_in_s, control_clock_s, csn_s} = st;
	assign rst_n = rsync[1];
	assign pd = ~pdn_s;

	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rsync <= 2'h0;
		end else begin
			rsync <= {rsync[0], 1'b1};
		end
	end

	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s1  <= {NA{1'b0}};
			s2  <= {NA{1'b0}};
			s3  <= {NA{1'b0}};
			stp <= {NA{1'b0}};
		end else begin
			s1  <= ain;
			s2  <= s1;
			s3  <= s2;
			stp <= st;
		end
	end

	// a pin change counts once the second and third stages agree
	genvar g;
	generate
		for (g = 0; g < NA; g = g + 1) begin : g_pin
			always @(posedge clock_i or negedge rst_n) begin
				if (!rst_n) begin
					st[g] <= 1'b0;
				end else if (s2[g] == s3[g]) begin
					st[g] <= s3[g];
				end
			end
		end
	endgenerate

	// straps are tracked only while powered down and frozen on release
	reg       k_par;
	reg [1:0] k_cad;
	reg       k_idif2;
	reg [1:0] k_odif;
	reg [1:0] k_obit;
	reg [3:0] k_cm;
	reg       k_tdm;
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			k_par   <= 1'b0;
			k_cad   <= 2'h0;
			k_idif2 <= 1'b0;
			k_odif  <= `SPC_FMT_MSB;
			k_obit  <= 2'h0;
			k_cm    <= 4'h0;
			k_tdm   <= 1'b0;
		end else if (pd) begin
			k_par   <= psn_s;
			k_cad   <= cad_s;
			k_idif2 <= idif2_s;
			k_odif  <= odif_s;
			k_obit  <= obit_s;
			k_cm    <= cm_s;
			k_tdm   <= tdm_s;
		end
	end

	wire master = k_cm[3] | ~k_cm[2];
	wire xforce = k_cm[3] | (k_cm == `SPC_CM_XT_OFF_A) | (k_cm == `SPC_CM_XT_OFF_B);
	wire ser    = ~k_par;

	// mode decode, control port routing and static selections
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ctl_serial_mode_o     <= 1'b0;
			ctl_i2c_mode_o        <= 1'b0;
			ctl_chip_addr_o       <= 2'h0;
			ctl_data_o            <= 1'b0;
			ctl_clock_o           <= 1'b0;
			ctl_select_n_o        <= 1'b1;
			control_data_out_o    <= 1'b0;
			control_data_out_oe_o <= 1'b0;
			sda_o                 <= 1'b0;
			sda_oe_o              <= 1'b0;
			input_format_o        <= 3'h0;
			filter_slow_o         <= 1'b0;
			filter_short_delay_o  <= 1'b0;
			dither_on_o           <= 1'b0;
			deemphasis_o          <= 2'h0;
			ref_source_o          <= `SPC_REF_XTAL;
			crystal_drive_out_o   <= 1'b0;
		end else begin
			ctl_serial_mode_o     <= ser & ~pd;
			ctl_i2c_mode_o        <= i2c_s & ~pd;
			ctl_chip_addr_o       <= ser ? k_cad : 2'h0;
			input_format_o        <= ser ? 3'h0 : {k_idif2, k_cad};
			ctl_data_o            <= ser & control_data_in_s;
			ctl_clock_o           <= ser & control_clock_s;
			ctl_select_n_o        <= ~ser | i2c_s | csn_s;
			control_data_out_o    <= ctl_reply_i;
			control_data_out_oe_o <= ~pd & ser & ~i2c_s & ~csn_s;
			sda_o                 <= 1'b0;
			sda_oe_o              <= ~pd & ser & i2c_s & ~ctl_reply_i;
			filter_slow_o         <= ser ? reg_slow_filter_i : control_clock_s;
			filter_short_delay_o  <= ser ? reg_short_delay_i : csn_s;
			dither_on_o           <= ~pd & dith_s;
			deemphasis_o          <= dsd_s ? 2'h0 : {dr_s, dl_s};
			if (!cksel_s) begin
				ref_source_o <= `SPC_REF_XTAL;
			end else if (k_tdm) begin
				ref_source_o <= `SPC_REF_CHAIN;
			end else begin
				ref_source_o <= `SPC_REF_EXT;
			end
			crystal_drive_out_o <= (pd | xforce) ? 1'b0 : ~xti_s;
		end
	end

	// input port capture, PCM or one-bit
	wire ibck_r = ibck_s & ~stp[`SPC_IX_IBCK];
	wire dclk_r = dclk_s & ~stp[`SPC_IX_DCLK];
	wire ilr_e  = ilr_s ^ stp[`SPC_IX_ILR];
	reg  [WW-1:0] shin;
	reg  [3:0]    dcnt;
	reg           lr_b;
	reg  [WW-1:0] iw;
	reg           iv;
	wire          in_rdy;
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			shin       <= {WW{1'b0}};
			dcnt       <= 4'h0;
			lr_b       <= 1'b0;
			iw         <= {WW{1'b0}};
			iv         <= 1'b0;
			overflow_o <= 1'b0;
		end else if (pd) begin
			shin       <= {WW{1'b0}};
			dcnt       <= 4'h0;
			iv         <= 1'b0;
			overflow_o <= 1'b0;
		end else begin
			if (iv && in_rdy) begin
				iv <= 1'b0;
			end
			if (dsd_s && dclk_r) begin
				shin <= {shin[WW-3:0], dl_s, dr_s};
				dcnt <= dcnt + 4'h1;
				if (dcnt == `SPC_DSD_LAST) begin
					iw <= {shin[WW-3:0], dl_s, dr_s};
					iv <= 1'b1;
					overflow_o <= overflow_o | (iv & ~in_rdy);
				end
			end else if (!dsd_s && ibck_r) begin
				shin <= {shin[WW-2:0], serial_audio_in_s};
				lr_b <= ilr_s;
				if (lr_b != ilr_s) begin
					iw <= shin;
					iv <= 1'b1;
					overflow_o <= overflow_o | (iv & ~in_rdy);
				end
			end
		end
	end

	// rate lock watch
	reg [23:0] ucnt;
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ucnt                <= 24'h0;
			unlock_status_out_o <= 1'b1;
		end else if (pd) begin
			ucnt                <= 24'h0;
			unlock_status_out_o <= 1'b1;
		end else begin
			if (dsd_s ? dclk_r : ilr_e) begin
				ucnt <= 24'h0;
			end else if (ucnt < UNL) begin
				ucnt <= ucnt + 24'h1;
			end
			unlock_status_out_o <= (ucnt >= UNL);
		end
	end

	// soft mute ramp
	reg  [15:0] mcnt;
	wire [15:0] mlim = MST << smt_s;
	wire        mreq = (ser ? reg_soft_mute_i : soft_mute_pin_s) | (semi_s & unlock_status_out_o);
	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			mcnt        <= 16'h0;
			mute_gain_o <= GMAX;
		end else if (pd) begin
			mcnt        <= 16'h0;
			mute_gain_o <= GMAX;
		end else if (mcnt + 16'h1 >= mlim) begin
			mcnt <= 16'h0;
			if (mreq && mute_gain_o != {GAIN_W{1'b0}}) begin
				mute_gain_o <= mute_gain_o - {{(GAIN_W-1){1'b0}}, 1'b1};
			end else if (!mreq && mute_gain_o != GMAX) begin
				mute_gain_o <= mute_gain_o + {{(GAIN_W-1){1'b0}}, 1'b1};
			end
		end else begin
			mcnt <= mcnt + 16'h1;
		end
	end

	// output port: clock generation or slave tracking, and serialiser
	reg  [11:0]   bdiv;
	reg           bck;
	reg  [5:0]    bitc;
	reg  [2:0]    slot;
	reg  [WW-1:0] sh;
	reg           upd;
	reg  [11:0]   mdiv;
	reg  [11:0]   mhalf;
	reg  [31:0]   mh32;
	wire          bwrap = (bdiv + 12'h1 >= BHALF);
	wire          adv = master ? (bwrap & bck) : (stp[`SPC_IX_OBCK] & ~obck_s);
	wire          last = (bitc == `SPC_SLOT_LAST);
	wire [2:0]    slast = k_tdm ? `SPC_TDM_LAST : `SPC_STEREO_LAST;
	wire [2:0]    nslot = (slot == slast) ? 3'h0 : slot + 3'h1;
	wire          out_v;
	wire [WW-1:0] out_d;
	wire          pull = ~pd & adv & last & (nslot < 3'h2);
	reg  [5:0]    wl;
	reg  [5:0]    off;
	wire [5:0]    rel = bitc - off;
	wire [5:0]    bidx = `SPC_SLOT_LAST - rel;

	always @* begin
		case (k_obit)
			2'h0: wl = `SPC_WL_0;
			2'h1: wl = `SPC_WL_1;
			2'h2: wl = `SPC_WL_2;
			default: wl = `SPC_WL_3;
		endcase
		if (k_odif == `SPC_FMT_LSB) begin
			off = `SPC_SLOT_BITS - wl;
		end else if (k_odif == `SPC_FMT_I2S) begin
			off = 6'h1;
		end else begin
			off = 6'h0;
		end
		case (k_cm[2:0])
			3'h0: mh32 = FRAME_CYC / (2 * `SPC_MCK_R0);
			3'h1: mh32 = FRAME_CYC / (2 * `SPC_MCK_R1);
			3'h2: mh32 = FRAME_CYC / (2 * `SPC_MCK_R2);
			3'h3: mh32 = FRAME_CYC / (2 * `SPC_MCK_R3);
			3'h4: mh32 = FRAME_CYC / (2 * `SPC_MCK_R4);
			3'h5: mh32 = FRAME_CYC / (2 * `SPC_MCK_R5);
			3'h6: mh32 = FRAME_CYC / (2 * `SPC_MCK_R6);
			default: mh32 = FRAME_CYC / (2 * `SPC_MCK_R7);
		endcase
		mhalf = mh32[11:0];
	end

	always @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			bdiv                 <= 12'h0;
			bck                  <= 1'b0;
			bitc                 <= 6'h0;
			slot                 <= 3'h0;
			sh                   <= {WW{1'b0}};
			upd                  <= 1'b0;
			mdiv                 <= 12'h0;
			master_clock_out_o   <= 1'b0;
			out_bit_clock_o      <= 1'b0;
			out_bit_clock_oe_o   <= 1'b1;
			out_frame_clock_o    <= 1'b0;
			out_frame_clock_oe_o <= 1'b1;
			serial_audio_out_o   <= 1'b0;
		end else if (pd) begin
			bdiv                 <= 12'h0;
			bck                  <= 1'b0;
			bitc                 <= 6'h0;
			slot                 <= 3'h0;
			sh                   <= {WW{1'b0}};
			upd                  <= 1'b0;
			mdiv                 <= 12'h0;
			master_clock_out_o   <= 1'b0;
			out_bit_clock_o      <= 1'b0;
			out_bit_clock_oe_o   <= master;
			out_frame_clock_o    <= 1'b0;
			out_frame_clock_oe_o <= master;
			serial_audio_out_o   <= 1'b0;
		end else begin
			out_bit_clock_oe_o   <= master;
			out_frame_clock_oe_o <= master;
			bdiv <= bwrap ? 12'h0 : bdiv + 12'h1;
			if (bwrap) begin
				bck <= ~bck;
			end
			out_bit_clock_o <= master & bck;
			if (!master) begin
				mdiv               <= 12'h0;
				master_clock_out_o <= 1'b0;
			end else if (mdiv + 12'h1 >= mhalf) begin
				mdiv               <= 12'h0;
				master_clock_out_o <= ~master_clock_out_o;
			end else begin
				mdiv <= mdiv + 12'h1;
			end
			upd <= adv;
			if (!master && (olr_s != stp[`SPC_IX_OLR])) begin
				bitc <= 6'h0;
			end else if (adv) begin
				bitc <= last ? 6'h0 : bitc + 6'h1;
				if (last) begin
					slot <= nslot;
					if (pull && out_v && mute_gain_o != {GAIN_W{1'b0}}) begin
						sh <= out_d;
					end else begin
						sh <= {WW{1'b0}};
					end
				end
			end
			if (upd) begin
				serial_audio_out_o <= (bitc >= off) && (rel < wl) && sh[bidx[4:0]];
				if (k_tdm) begin
					out_frame_clock_o <= master & (slot == 3'h0) & (bitc == 6'h0);
				end else begin
					out_frame_clock_o <= master & (slot[0] ^ (k_odif != `SPC_FMT_I2S));
				end
			end
		end
	end

	spc_buf2 #(
		.W     (WW),
		.DEPTH (2)
	) u_buf (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n),
		.clear_i     (pd),
		.in_data_i   (iw),
		.in_valid_i  (iv),
		.in_ready_o  (in_rdy),
		.out_data_o  (out_d),
		.out_valid_o (out_v),
		.out_ready_i (pull)
	);
endmodule // spc_pin_ctrl

// ===== verif/spc_audio_src.sv
// behavioural audio source driving the pcm input link
`timescale 1ns/1ps
module spc_audio_src #(
	parameter logic [31:0] PAT = 32'hc3a5_9617
) (
	input  wire logic run_i,
	output logic      bit_clock_o,
	output logic      frame_clock_o,
	output logic      data_o
);
	int n = 0;
	initial begin
		bit_clock_o = 1'b0;
		frame_clock_o = 1'b0;
		data_o = 1'b0;
		#3;
		forever begin
			if (run_i) begin
				frame_clock_o = n[5];
				data_o = PAT[~n[4:0]];
				#40 bit_clock_o = 1'b1;
				#40 bit_clock_o = 1'b0;
				n = n + 1;
			end else begin
				// clock stands still; data keeps changing so no stale bit looks valid
				data_o = ~data_o;
				#40;
			end
		end
	end
endmodule // spc_audio_src

// ===== verif/spc_pin_ctrl_props.sv
// concurrent checks on the pin control block ports
`timescale 1ns/1ps
module spc_pin_ctrl_props #(
	parameter GAIN_W = 8
) (
	input wire              clock_i,
	input wire              rstn_i,
	input wire              power_down_n_i,
	input wire              parallel_serial_sel_i,
	input wire              bus_type_sel_i,
	input wire [3:0]        output_clock_mode_sel_i,
	input wire              soft_mute_pin_i,
	input wire              dither_enable_i,
	input wire              onebit_in_left_i,
	input wire              onebit_in_right_i,
	input wire              onebit_mode_sel_i,
	input wire              control_chip_select_n_i,
	input wire              out_frame_clock_o,
	input wire              out_frame_clock_oe_o,
	input wire              out_bit_clock_o,
	input wire              out_bit_clock_oe_o,
	input wire              serial_audio_out_o,
	input wire              master_clock_out_o,
	input wire              crystal_drive_out_o,
	input wire              unlock_status_out_o,
	input wire              control_data_out_oe_o,
	input wire              ctl_serial_mode_o,
	input wire              dither_on_o,
	input wire [1:0]        deemphasis_o,
	input wire [GAIN_W-1:0] mute_gain_o
);
	// pd and run are only true once the pin has settled past the synchroniser
	logic [3:0] pd_cnt;
	logic [3:0] run_cnt;
	wire        pd  = (pd_cnt == 4'hf);
	wire        run = (run_cnt == 4'hf);
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pd_cnt  <= 4'h0;
			run_cnt <= 4'h0;
		end else begin
			pd_cnt  <= power_down_n_i ? 4'h0 : (pd ? pd_cnt : pd_cnt + 4'h1);
			run_cnt <= !power_down_n_i ? 4'h0 : (run ? run_cnt : run_cnt + 4'h1);
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_pd_unlock_high: assert property (pd |-> unlock_status_out_o)
		else $error("unlock output low in power-down");
	a_pd_outputs_low: assert property (pd |-> !serial_audio_out_o && !master_clock_out_o && !control_data_out_oe_o)
		else $error("output not parked in power-down");
	a_pd_clock_dir: assert property (pd && $past(output_clock_mode_sel_i, 8) == output_clock_mode_sel_i |->
		out_frame_clock_oe_o == (output_clock_mode_sel_i[3] | ~output_clock_mode_sel_i[2])
		&& out_bit_clock_oe_o == out_frame_clock_oe_o && !out_frame_clock_o && !out_bit_clock_o)
		else $error("output clock pins wrong in power-down");
	a_xtal_forced_low: assert property (pd || (run && (output_clock_mode_sel_i[3] || output_clock_mode_sel_i[2:1] == 2'h3)) |->
		!crystal_drive_out_o)
		else $error("crystal drive not held low");
	a_control_data_out_enable_on: assert property ((run && !parallel_serial_sel_i && !bus_type_sel_i && !control_chip_select_n_i)[*8] |->
		control_data_out_oe_o)
		else $error("control data output not driven while selected");
	a_mode_frozen: assert property (pd ##1 power_down_n_i[*8] |-> ctl_serial_mode_o == !$past(parallel_serial_sel_i, 8))
		else $error("control mode differs from strap at release");
	a_dither_follow: assert property (run && $rose(dither_enable_i) |-> ##[2:8] dither_on_o)
		else $error("dither did not turn on");
	a_deemph_pins: assert property ((run && !onebit_mode_sel_i && $stable({onebit_in_right_i, onebit_in_left_i}))[*8] |->
		deemphasis_o == {onebit_in_right_i, onebit_in_left_i})
		else $error("de-emphasis code differs from pins");
	a_mute_no_rise: assert property ((run && parallel_serial_sel_i && soft_mute_pin_i)[*8] |->
		mute_gain_o <= $past(mute_gain_o))
		else $error("gain rose while mute pin high");
endmodule // spc_pin_ctrl_props
bind spc_pin_ctrl spc_pin_ctrl_props #(.GAIN_W(GAIN_W)) u_spc_pin_ctrl_props (.*);

// ===== verif/tb_spc_pin_ctrl.sv
// self-checking bench for the pin control block
`timescale 1ns/1ps
module tb_spc_pin_ctrl;
	localparam int FRAME = 3072;
	localparam logic [31:0] PAT = 32'hc3a5_9617;
	logic clock_i, rstn_i, power_down_n_i, parallel_serial_sel_i, bus_type_sel_i, input_format_sel_2_i, tdm_sel_i;
	logic soft_mute_pin_i, mute_semi_auto_sel_i, dither_enable_i, onebit_in_left_i, onebit_in_right_i, link_run;
	logic ref_clock_source_sel_i, sda_drv, control_clock_i, control_chip_select_n_i, reg_soft_mute_i, watch;
	logic reg_slow_filter_i, reg_short_delay_i, ctl_reply_i;
	logic [1:0] chip_addr_straps_i, output_format_sel_i, output_word_length_sel_i, mute_time_sel_i;
	logic [3:0] output_clock_mode_sel_i;
	logic [31:0] rx;
	wire in_frame_clock_i, in_bit_clock_i, serial_audio_in_i, out_frame_clock_o, out_frame_clock_oe_o;
	wire out_bit_clock_o, out_bit_clock_oe_o, serial_audio_out_o, master_clock_out_o, crystal_drive_out_o;
	wire unlock_status_out_o, control_data_out_o, control_data_out_oe_o, sda_o, sda_oe_o, ctl_serial_mode_o;
	wire ctl_i2c_mode_o, ctl_data_o, ctl_clock_o, ctl_select_n_o, filter_slow_o, filter_short_delay_o;
	wire dither_on_o, overflow_o;
	wire [1:0] ctl_chip_addr_o, deemphasis_o, ref_source_o;
	wire [2:0] input_format_o;
	wire [7:0] mute_gain_o;
	logic onebit_in_clock_i, onebit_mode_sel_i;
	wire crystal_in_i = 1'b0;
	wire out_frame_clock_i = out_frame_clock_oe_o & out_frame_clock_o;
	wire out_bit_clock_i = out_bit_clock_oe_o & out_bit_clock_o;
	// data line is pulled up and pulled low by whichever party enables
	wire control_data_in_i = sda_drv & ~(bus_type_sel_i & sda_oe_o);
	int errors, comparisons, cyc, good, bad;
	spc_pin_ctrl #(.UNLOCK_CYC(2000), .MUTE_STEP_CYC(4), .FRAME_CYC(FRAME)) u_spc_pin_ctrl (.*);
	spc_audio_src #(.PAT(PAT)) u_spc_audio_src (.run_i(link_run), .bit_clock_o(in_bit_clock_i),
		.frame_clock_o(in_frame_clock_i), .data_o(serial_audio_in_i));
	always #4 clock_i = ~clock_i;
	always @(posedge clock_i) cyc <= cyc + 1;
	always @(posedge out_bit_clock_o) rx <= {rx[30:0], serial_audio_out_o};
	always @(out_frame_clock_o) begin
		if (watch && rx === PAT)
			good++;
		else if (watch && rx !== 32'h0)
			bad++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// no control word is ever written here, so the settle time after release never comes due
	task automatic pd_cycle(input logic p, input logic [3:0] c, input logic t, input logic [2:0] f);
		power_down_n_i = 1'b0;
		wait_cyc(8);
		parallel_serial_sel_i = p;
		output_clock_mode_sel_i = c;
		tdm_sel_i = t;
		{input_format_sel_2_i, chip_addr_straps_i} = f;
		wait_cyc(10);
		power_down_n_i = 1'b1;
		wait_cyc(20);
	endtask
	task automatic t_powerdown();
		wait_cyc(20);
		check(unlock_status_out_o, 1'b1);
		check({serial_audio_out_o, master_clock_out_o, crystal_drive_out_o, control_data_out_oe_o}, 4'h0);
		check({out_frame_clock_oe_o, out_bit_clock_oe_o}, 2'h0);
		output_clock_mode_sel_i = 4'h9;
		wait_cyc(10);
		check({out_frame_clock_oe_o, out_bit_clock_oe_o, out_frame_clock_o, out_bit_clock_o}, 4'hc);
	endtask
	task automatic t_mclk();
		int ratio[7] = '{64, 128, 192, 256, 384, 512, 768};
		int t0;
		for (int k = 0; k < 7; k++) begin
			// codes 4 to 6 are slave modes, so the upper ratios run with the top mode bit set
			pd_cycle(1'b1, (k < 4) ? k[3:0] : {1'b1, k[2:0]}, 1'b0, 3'h0);
			@(posedge master_clock_out_o);
			@(negedge clock_i);
			t0 = cyc;
			@(posedge master_clock_out_o);
			@(negedge clock_i);
			check(cyc - t0, FRAME / ratio[k]);
			check(crystal_drive_out_o, k < 4);
		end
		pd_cycle(1'b1, 4'h6, 1'b0, 3'h0);
		check(crystal_drive_out_o, 1'b0);
		pd_cycle(1'b1, 4'h7, 1'b0, 3'h0);
		check(crystal_drive_out_o, 1'b0);
	endtask
	task automatic t_control();
		pd_cycle(1'b0, 4'h4, 1'b0, 3'h6);
		control_chip_select_n_i = 1'b0;
		reg_slow_filter_i = 1'b1;
		wait_cyc(10);
		check({ctl_serial_mode_o, ctl_i2c_mode_o, ctl_chip_addr_o, input_format_o}, 7'h50);
		check({control_data_out_oe_o, filter_slow_o, filter_short_delay_o}, 3'h6);
		check({ctl_data_o, ctl_clock_o, ctl_select_n_o, control_data_out_o, sda_o}, 5'h12);
		bus_type_sel_i = 1'b1;
		ctl_reply_i = 1'b0;
		wait_cyc(10);
		check({ctl_i2c_mode_o, sda_oe_o, control_data_out_oe_o, control_data_in_i}, 4'hc);
		{bus_type_sel_i, ctl_reply_i, control_chip_select_n_i, reg_slow_filter_i} = 4'h6;
		pd_cycle(1'b1, 4'h4, 1'b1, 3'h5);
		control_clock_i = 1'b1;
		wait_cyc(10);
		check({ctl_serial_mode_o, input_format_o, filter_slow_o, filter_short_delay_o}, 6'h17);
		for (int d = 0; d < 4; d++) begin
			{onebit_in_right_i, onebit_in_left_i} = d[1:0];
			dither_enable_i = d[0];
			ref_clock_source_sel_i = d[1];
			wait_cyc(10);
			check({deemphasis_o, dither_on_o, ref_source_o}, {d[1:0], d[0], d[1], 1'b0});
		end
		pd_cycle(1'b1, 4'h4, 1'b0, 3'h5);
		check(ref_source_o, 2'h1);
		{ref_clock_source_sel_i, dither_enable_i} = 2'h0;
	endtask
	task automatic t_link();
		pd_cycle(1'b1, 4'h0, 1'b0, 3'h0);
		link_run = 1'b1;
		wait_cyc(3000);
		watch = 1'b1;
		wait_cyc(8000);
		watch = 1'b0;
		check(good > 4, 1'b1);
		check(bad, 0);
		check({unlock_status_out_o, overflow_o}, 2'h1);
		parallel_serial_sel_i = 1'b0;
		wait_cyc(10);
		check(ctl_serial_mode_o, 1'b0);
		parallel_serial_sel_i = 1'b1;
	endtask
	task automatic t_mute();
		soft_mute_pin_i = 1'b1;
		wait_cyc(1100);
		check(mute_gain_o, 8'h00);
		soft_mute_pin_i = 1'b0;
		wait_cyc(1100);
		check(mute_gain_o, 8'hff);
		{mute_time_sel_i, soft_mute_pin_i} = 3'h3;
		wait_cyc(400);
		check(mute_gain_o >= 8'hcb && mute_gain_o <= 8'hcf, 1'b1);
		{mute_time_sel_i, soft_mute_pin_i} = 3'h0;
		wait_cyc(1100);
		{mute_semi_auto_sel_i, link_run} = 2'h2;
		wait_cyc(3200);
		check({unlock_status_out_o, mute_gain_o}, 9'h100);
		link_run = 1'b1;
		wait_cyc(1700);
		check({unlock_status_out_o, mute_gain_o}, 9'h0ff);
		link_run = 1'b0;
		wait_cyc(2600);
		check(unlock_status_out_o, 1'b1);
		{onebit_mode_sel_i, onebit_in_right_i, onebit_in_left_i} = 3'h7;
		repeat (300) begin
			wait_cyc(5);
			onebit_in_clock_i = ~onebit_in_clock_i;
		end
		check({deemphasis_o, unlock_status_out_o}, 3'h0);
		power_down_n_i = 1'b0;
		wait_cyc(10);
		check({unlock_status_out_o, overflow_o, mute_gain_o}, 10'h2ff);
	endtask
	initial begin
		{clock_i, rstn_i, power_down_n_i, bus_type_sel_i, input_format_sel_2_i, tdm_sel_i, soft_mute_pin_i} = 7'h0;
		{mute_semi_auto_sel_i, dither_enable_i, onebit_in_left_i, onebit_in_right_i, link_run, watch} = 6'h0;
		{onebit_in_clock_i, onebit_mode_sel_i} = 2'h0;
		{ref_clock_source_sel_i, control_clock_i, reg_soft_mute_i, reg_slow_filter_i, reg_short_delay_i} = 5'h0;
		{chip_addr_straps_i, output_format_sel_i, output_word_length_sel_i, mute_time_sel_i} = 8'h0;
		{parallel_serial_sel_i, sda_drv, control_chip_select_n_i, ctl_reply_i} = 4'hf;
		output_clock_mode_sel_i = 4'h4;
		wait_cyc(6);
		rstn_i = 1'b1;
		t_powerdown();
		t_mclk();
		t_control();
		t_link();
		t_mute();
		print_verdict();
	end
	initial begin
		#480000;
		errors++;
		print_verdict();
	end
endmodule // tb_spc_pin_ctrl
